// ### rfi_pkg.sv
// Constants, register map and carrier types of the reset flag block.
// Assumes a single system clock and an AXI4-Lite master with 8-bit addresses.
package rfi_pkg;

    localparam int ADDR_W = 8;

    // Byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_IRQ_ST = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_SEQ = 8'h0c;
    localparam logic [7:0] OFS_CFG_BASE = 8'h10;

    // Configuration register indexes, word i at OFS_CFG_BASE + 4*i
    localparam int CFG_THR = 0;
    localparam int CFG_WATCHDOG_CONTROL_REG = 1;
    localparam int CFG_PORT_DATA = 2;
    localparam int CFG_PORT_DIR = 3;
    localparam int CFG_NVD = 4;
    localparam int CFG_NVC = 5;
    localparam int CFG_WORK = 6;
    localparam int CFG_LKP_LO = 7;
    localparam int CFG_LKP_HB = 8;
    localparam int CFG_LKP_HI = 9;
    localparam int CFG_IRQC0 = 10;
    localparam int CFG_IRQC1 = 11;
    localparam int CFG_TMRC = 12;
    localparam int NCFG = 13;

    typedef logic [NCFG-1:0][7:0] rfi_cfg_regs_t;

    // Reset values, index 12 first
    localparam rfi_cfg_regs_t CFG_RST = {8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'hff, 8'hff, 8'h53, 8'h55};
    // Implemented bits
    localparam rfi_cfg_regs_t CFG_MASK = {8'hff, 8'hff, 8'hff, 8'h07,
        8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    // Kept across every watchdog reset
    localparam logic [NCFG-1:0] CFG_KEEP_WDT = 13'h03c0;
    // Cleared even by a halt-mode watchdog reset
    localparam logic [NCFG-1:0] CFG_CLR_HALT = 13'h0010;

    // Flag bits
    localparam int FLAG_TO = 0;
    localparam int FLAG_PD = 1;
    localparam int FLAG_LVR = 2;
    localparam int FLAG_THR = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // Interrupt bits, one per reset source
    localparam int IRQ_W = 5;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

    // Defined supply threshold codes
    localparam logic [7:0] THR_CODE_A = 8'h55;
    localparam logic [7:0] THR_CODE_B = 8'h33;
    localparam logic [7:0] THR_CODE_C = 8'h99;
    localparam logic [7:0] THR_CODE_D = 8'haa;

    // Timing counts
    localparam logic [4:0] STAB_FAST_CYC = 5'h10;
    localparam logic [4:0] STAB_SLOW_CYC = 5'h02;
    localparam logic [1:0] DEB_SLOW_TICKS = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_RUN, ST_APPLY, ST_STAB} rfi_st_t;
    typedef enum logic [2:0] {
        SRC_POR, SRC_LVR, SRC_WDT_RUN, SRC_WDT_HALT, SRC_THR
    } rfi_src_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } rfi_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rfi_axi_rsp_t;

    typedef struct packed {
        rfi_st_t state;
        rfi_src_t src;
        logic [4:0] stab_cnt;
        logic deb_act;
        logic [1:0] deb_cnt;
        logic [3:0] flags;
        rfi_cfg_regs_t cfg;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic hold;
        logic pcsp_clr;
        logic wdt_clr;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wlane;
        rfi_axi_rsp_t rsp;
    } rfi_state_t;

endpackage : rfi_pkg

// ### rfi_reset_flags.sv
// Reset source sequencer, reset flags and reset-value loading.
// Assumes all inputs synchronous to SYS_CLK and an AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Halt-mode watchdog reset clears PC, SP and nonvolatile data, sets timeout flag.
// - Halt-mode watchdog reset waits 16 fast or 2 slow clocks before resuming.
// - Power-on reset clears timeout and powerdown flags.
// - Low-voltage reset keeps both flags unchanged.
// - Running watchdog reset sets timeout flag, keeps powerdown flag.
// - Halt-mode watchdog reset sets both flags.
// - Power-on reset disables all interrupt sources.
// - Power-on reset clears the watchdog, which then counts at once.
// - Power-on reset switches the timer off.
// - Power-on reset makes all port pins inputs, data and direction all ones.
// - Power-on reset points the stack pointer at the stack top.
// - Full resets load threshold 0x55 and watchdog control 0x53; halt keeps.
// - Nonvolatile data clears on every reset; control loads 0xf on full ones.
// - Working and lookup registers load on power-on, low-voltage and threshold resets, kept on watchdog.
// - Running watchdog reset equals low-voltage reset, but sets timeout not LVR flag and keeps working and lookup registers.
// - Undefined threshold write resets after 2 slow ticks, sets its flag.
// - Power-on reset zeroes the program counter.
module rfi_reset_flags #(
    parameter logic [4:0] STAB_FAST = rfi_pkg::STAB_FAST_CYC,
    parameter logic [4:0] STAB_SLOW = rfi_pkg::STAB_SLOW_CYC,
    parameter logic [1:0] DEB_TICKS = rfi_pkg::DEB_SLOW_TICKS
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic LV_DETECT,
    input wire logic WDT_TIMEOUT,
    input wire logic CPU_HALTED,
    input wire logic SLOW_CLK_SEL,
    input wire logic SLOW_OSC_TICK,
    input wire rfi_pkg::rfi_axi_req_t AXI_REQ,
    output rfi_pkg::rfi_axi_rsp_t AXI_RSP,
    output rfi_pkg::rfi_cfg_regs_t CFG_REGS,
    output logic TIMEOUT_FLAG,
    output logic POWERDOWN_FLAG,
    output logic CORE_HOLD,
    output logic PC_SP_CLEAR,
    output logic WDT_CLEAR,
    output logic IRQ
);

    rfi_pkg::rfi_state_t s_q;
    rfi_pkg::rfi_state_t s_d;
    rfi_pkg::rfi_state_t s_rst;

    // Reset image: power-on source pending, applied on the first enabled edge
    always_comb begin
        s_rst = '0;
        s_rst.state = rfi_pkg::ST_APPLY;
        s_rst.src = rfi_pkg::SRC_POR;
        s_rst.hold = 1'b1;
        s_rst.flags = rfi_pkg::FLAGS_RST;
        s_rst.cfg = rfi_pkg::CFG_RST;
        s_rst.irq_st = rfi_pkg::IRQ_RST;
        s_rst.irq_mask = rfi_pkg::IRQ_RST;
        s_rst.rsp.awready = 1'b1;
        s_rst.rsp.wready = 1'b1;
        s_rst.rsp.arready = 1'b1;
    end

    function automatic logic thr_defined(input logic [7:0] v);
        thr_defined = (v == rfi_pkg::THR_CODE_A) || (v == rfi_pkg::THR_CODE_B)
            || (v == rfi_pkg::THR_CODE_C) || (v == rfi_pkg::THR_CODE_D);
    endfunction : thr_defined

    // Decodes a configuration word; returns index and hit
    function automatic logic cfg_hit(input logic [7:0] a, output int idx);
        logic [7:0] rel;
        rel = a - rfi_pkg::OFS_CFG_BASE;
        idx = int'(rel[7:2]);
        cfg_hit = (a >= rfi_pkg::OFS_CFG_BASE) && (a[1:0] == 2'b00)
            && (idx < rfi_pkg::NCFG);
    endfunction : cfg_hit

    // Read view of one address; ok is low for an unmapped one
    function automatic logic [31:0] read_word(input rfi_pkg::rfi_state_t s,
        input logic [7:0] a, output logic ok);
        int idx;
        logic [31:0] w;
        idx = 0;
        w = 32'h0000_0000;
        ok = 1'b1;
        if (cfg_hit(a, idx)) begin
            w = {24'h000000, s.cfg[idx]};
        end else begin
            unique case (a)
                rfi_pkg::OFS_FLAGS: begin
                    w = {28'h0000000, s.flags};
                end
                rfi_pkg::OFS_IRQ_ST: begin
                    w = {27'h0000000, s.irq_st};
                end
                rfi_pkg::OFS_IRQ_MASK: begin
                    w = {27'h0000000, s.irq_mask};
                end
                rfi_pkg::OFS_SEQ: begin
                    w = {26'h0000000, s.deb_act, s.state, s.src};
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
        read_word = w;
    endfunction : read_word

    // Register image after a reset of the given source
    function automatic rfi_pkg::rfi_cfg_regs_t cfg_after(
        input rfi_pkg::rfi_src_t src, input rfi_pkg::rfi_cfg_regs_t cur);
        rfi_pkg::rfi_cfg_regs_t c;
        c = cur;
        for (int i = 0; i < rfi_pkg::NCFG; i++) begin
            unique case (src)
                rfi_pkg::SRC_WDT_HALT: begin
                    if (rfi_pkg::CFG_CLR_HALT[i]) begin
                        c[i] = rfi_pkg::CFG_RST[i];
                    end
                end
                rfi_pkg::SRC_WDT_RUN: begin
                    if (!rfi_pkg::CFG_KEEP_WDT[i]) begin
                        c[i] = rfi_pkg::CFG_RST[i];
                    end
                end
                default: begin
                    c[i] = rfi_pkg::CFG_RST[i];
                end
            endcase
        end
        cfg_after = c;
    endfunction : cfg_after

    always_comb begin
        int widx;
        logic whit;
        logic thr_fire;
        logic full;
        logic [31:0] rd;
        logic rd_ok;
        widx = 0;
        whit = 1'b0;
        thr_fire = 1'b0;
        full = 1'b0;
        rd = 32'h0000_0000;
        rd_ok = 1'b0;
        s_d = s_q;
        s_d.pcsp_clr = 1'b0;
        s_d.wdt_clr = 1'b0;

        // Write address and data, taken in either order
        if (s_q.rsp.awready && AXI_REQ.awvalid) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = AXI_REQ.awaddr;
        end
        if (s_q.rsp.wready && AXI_REQ.wvalid) begin
            s_d.w_got = 1'b1;
            s_d.wdata = AXI_REQ.wdata[7:0];
            s_d.wlane = AXI_REQ.wstrb[0];
        end
        if (s_q.rsp.bvalid && AXI_REQ.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_d.aw_got && s_d.w_got && !s_d.rsp.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = rfi_pkg::RESP_OKAY;
            whit = cfg_hit(s_d.awaddr, widx);
            if (whit) begin
                if (s_d.wlane) begin
                    s_d.cfg[widx] = s_d.wdata & rfi_pkg::CFG_MASK[widx];
                    if (widx == rfi_pkg::CFG_THR && !thr_defined(s_d.wdata))
                    begin
                        s_d.deb_act = 1'b1;
                        s_d.deb_cnt = 2'h0;
                    end
                end
            end else if (s_d.awaddr == rfi_pkg::OFS_FLAGS) begin
                if (s_d.wlane) begin
                    s_d.flags = s_q.flags & ~s_d.wdata[3:0];
                end
            end else if (s_d.awaddr == rfi_pkg::OFS_IRQ_ST) begin
                if (s_d.wlane) begin
                    s_d.irq_st = s_q.irq_st & ~s_d.wdata[rfi_pkg::IRQ_W-1:0];
                end
            end else if (s_d.awaddr == rfi_pkg::OFS_IRQ_MASK) begin
                if (s_d.wlane) begin
                    s_d.irq_mask = s_d.wdata[rfi_pkg::IRQ_W-1:0];
                end
            end else if (s_d.awaddr != rfi_pkg::OFS_SEQ) begin
                s_d.rsp.bresp = rfi_pkg::RESP_SLVERR;
            end
        end
        s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;

        // Read channel
        if (s_q.rsp.rvalid && AXI_REQ.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (s_q.rsp.arready && AXI_REQ.arvalid) begin
            rd = read_word(s_q, AXI_REQ.araddr, rd_ok);
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = rd;
            s_d.rsp.rresp = rd_ok ? rfi_pkg::RESP_OKAY : rfi_pkg::RESP_SLVERR;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // Debounce of an undefined threshold code on slow oscillator ticks
        if (s_q.deb_act && SLOW_OSC_TICK) begin
            s_d.deb_cnt = s_q.deb_cnt + 2'h1;
            if (s_q.deb_cnt + 2'h1 >= DEB_TICKS) begin
                thr_fire = 1'b1;
            end
        end

        unique case (s_q.state)
            rfi_pkg::ST_RUN: begin
                // Sources sampled on the clock, recorded for the apply cycle
                if (LV_DETECT) begin
                    s_d.src = rfi_pkg::SRC_LVR;
                    s_d.state = rfi_pkg::ST_APPLY;
                    s_d.hold = 1'b1;
                end else if (WDT_TIMEOUT) begin
                    s_d.src = CPU_HALTED ? rfi_pkg::SRC_WDT_HALT
                        : rfi_pkg::SRC_WDT_RUN;
                    s_d.state = rfi_pkg::ST_APPLY;
                    s_d.hold = 1'b1;
                end else if (thr_fire) begin
                    s_d.src = rfi_pkg::SRC_THR;
                    s_d.state = rfi_pkg::ST_APPLY;
                    s_d.hold = 1'b1;
                end
            end
            rfi_pkg::ST_APPLY: begin
                full = (s_q.src != rfi_pkg::SRC_WDT_HALT);
                // All registers take their values in this one cycle
                s_d.cfg = cfg_after(s_q.src, s_d.cfg);
                // Flags per source; debounce cancelled except on a halt reset
                unique case (s_q.src)
                    rfi_pkg::SRC_POR: begin
                        s_d.flags = rfi_pkg::FLAGS_RST;
                        s_d.deb_act = 1'b0;
                    end
                    rfi_pkg::SRC_LVR: begin
                        s_d.flags[rfi_pkg::FLAG_LVR] = 1'b1;
                        s_d.deb_act = 1'b0;
                    end
                    rfi_pkg::SRC_WDT_RUN: begin
                        s_d.flags[rfi_pkg::FLAG_TO] = 1'b1;
                        s_d.deb_act = 1'b0;
                    end
                    rfi_pkg::SRC_WDT_HALT: begin
                        s_d.flags[rfi_pkg::FLAG_TO] = 1'b1;
                        s_d.flags[rfi_pkg::FLAG_PD] = 1'b1;
                    end
                    rfi_pkg::SRC_THR: begin
                        s_d.flags[rfi_pkg::FLAG_THR] = 1'b1;
                        s_d.deb_act = 1'b0;
                    end
                    default: begin
                        s_d.deb_act = 1'b0;
                    end
                endcase
                // Sticky event bits; set beats a same-cycle clear
                s_d.irq_st[s_q.src] = 1'b1;
                s_d.pcsp_clr = 1'b1;
                if (full) begin
                    s_d.wdt_clr = 1'b1;
                    s_d.hold = 1'b0;
                    s_d.state = rfi_pkg::ST_RUN;
                end else begin
                    s_d.stab_cnt = SLOW_CLK_SEL ? STAB_SLOW
                        : STAB_FAST;
                    s_d.state = rfi_pkg::ST_STAB;
                end
            end
            rfi_pkg::ST_STAB: begin
                // Clock stabilisation wait before resuming
                s_d.stab_cnt = s_q.stab_cnt - 5'h01;
                if (s_q.stab_cnt <= 5'h01) begin
                    s_d.hold = 1'b0;
                    s_d.state = rfi_pkg::ST_RUN;
                end
            end
            default: begin
                s_d.state = rfi_pkg::ST_RUN;
            end
        endcase

        s_d.irq = |(s_d.irq_st & s_d.irq_mask);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s_q <= s_rst;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign AXI_RSP = s_q.rsp;
    assign CFG_REGS = s_q.cfg;
    assign TIMEOUT_FLAG = s_q.flags[rfi_pkg::FLAG_TO];
    assign POWERDOWN_FLAG = s_q.flags[rfi_pkg::FLAG_PD];
    assign CORE_HOLD = s_q.hold;
    assign PC_SP_CLEAR = s_q.pcsp_clr;
    assign WDT_CLEAR = s_q.wdt_clr;
    assign IRQ = s_q.irq;

endmodule : rfi_reset_flags

`default_nettype wire

// ### rfi_reset_flags_asserts.sv
// Checker for the reset flag block, bound onto its top module.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module rfi_reset_flags_asserts (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic LV_DETECT,
    input wire logic WDT_TIMEOUT,
    input wire logic CPU_HALTED,
    input wire logic SLOW_CLK_SEL,
    input wire rfi_pkg::rfi_cfg_regs_t CFG_REGS,
    input wire logic TIMEOUT_FLAG,
    input wire logic POWERDOWN_FLAG,
    input wire logic CORE_HOLD,
    input wire logic PC_SP_CLEAR,
    input wire logic WDT_CLEAR
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    a_por_values: assert property (
        $fell(SYS_RST) |-> !TIMEOUT_FLAG && !POWERDOWN_FLAG && CORE_HOLD
        && CFG_REGS == rfi_pkg::CFG_RST) else $error("Reset values wrong");
    a_por_pulses: assert property (
        $fell(SYS_RST) && CLK_EN |=> PC_SP_CLEAR && WDT_CLEAR ##1 !CORE_HOLD)
        else $error("Power-on apply missing");
    a_full_hold: assert property (
        WDT_CLEAR && CLK_EN |-> PC_SP_CLEAR && !CORE_HOLD ##1 !WDT_CLEAR
        && !PC_SP_CLEAR) else $error("Full reset hold wrong");
    a_stab_fast: assert property (
        PC_SP_CLEAR && !WDT_CLEAR && !SLOW_CLK_SEL |-> CORE_HOLD[*8] ##1
        CORE_HOLD[*8] ##1 !CORE_HOLD) else $error("Fast wait wrong");
    a_stab_slow: assert property (
        PC_SP_CLEAR && !WDT_CLEAR && SLOW_CLK_SEL |-> CORE_HOLD[*2] ##1
        !CORE_HOLD) else $error("Slow wait wrong");
    a_halt_flags: assert property (
        PC_SP_CLEAR && !WDT_CLEAR |-> TIMEOUT_FLAG && POWERDOWN_FLAG
        && CFG_REGS[rfi_pkg::CFG_NVD] == 8'h00 && CFG_REGS[rfi_pkg::CFG_THR]
        == $past(CFG_REGS[rfi_pkg::CFG_THR])) else $error("Halt reset wrong");
    a_wdt_run: assert property (
        WDT_TIMEOUT && !LV_DETECT && !CPU_HALTED && CLK_EN && !CORE_HOLD |=>
        ##1 WDT_CLEAR && TIMEOUT_FLAG && POWERDOWN_FLAG ==
        $past(POWERDOWN_FLAG, 2)) else $error("Running timeout wrong");
    a_lvr_keep: assert property (
        LV_DETECT && CLK_EN && !CORE_HOLD |=> ##1 WDT_CLEAR && TIMEOUT_FLAG
        == $past(TIMEOUT_FLAG, 2) && POWERDOWN_FLAG == $past(POWERDOWN_FLAG, 2))
        else $error("Low-voltage flags changed");
    a_freeze_hold: assert property (
        !CLK_EN |=> $stable(CFG_REGS) && $stable(CORE_HOLD)
        && $stable(TIMEOUT_FLAG)) else $error("State moved while frozen");
endmodule : rfi_reset_flags_asserts
bind rfi_reset_flags rfi_reset_flags_asserts u_chk (.SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .LV_DETECT(LV_DETECT),
    .WDT_TIMEOUT(WDT_TIMEOUT), .CPU_HALTED(CPU_HALTED),
    .SLOW_CLK_SEL(SLOW_CLK_SEL), .CFG_REGS(CFG_REGS),
    .TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG),
    .CORE_HOLD(CORE_HOLD), .PC_SP_CLEAR(PC_SP_CLEAR), .WDT_CLEAR(WDT_CLEAR));
`default_nettype wire

// ### rfi_reset_flags_tb_top.sv
// Self-checking bench of the reset flag block.
// Assumes the checker is bound in; the bench is the AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none
module rfi_reset_flags_tb_top;
    logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, lv = 1'b0;
    logic wdt = 1'b0, halted = 1'b0, slow = 1'b0, tick = 1'b0;
    rfi_pkg::rfi_axi_req_t req = '0;
    rfi_pkg::rfi_axi_rsp_t rsp;
    rfi_pkg::rfi_cfg_regs_t cfg, mdl;
    logic to_f, pd_f, hold, pcsp, wclr, irq;
    logic [31:0] rd_v;
    logic [1:0] rs;
    int fail_count = 0, n_compared = 0, cyc = 0, hc = 0, nf = 0;
    logic [7:0] codes [4] = '{rfi_pkg::THR_CODE_A, rfi_pkg::THR_CODE_B,
        rfi_pkg::THR_CODE_C, rfi_pkg::THR_CODE_D};
    always #50 sys_clk = ~sys_clk;
    rfi_reset_flags uut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .CLK_EN(clk_en), .LV_DETECT(lv), .WDT_TIMEOUT(wdt),
        .CPU_HALTED(halted), .SLOW_CLK_SEL(slow), .SLOW_OSC_TICK(tick),
        .AXI_REQ(req), .AXI_RSP(rsp), .CFG_REGS(cfg), .TIMEOUT_FLAG(to_f),
        .POWERDOWN_FLAG(pd_f), .CORE_HOLD(hold), .PC_SP_CLEAR(pcsp),
        .WDT_CLEAR(wclr), .IRQ(irq));
    task automatic conclude();
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
            if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rs = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd_v = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    // Hold cycles counted from the PC/SP clear pulse on
    task automatic wait_apply();
        hc = 0;
        while (!pcsp) @(posedge sys_clk);
        while (hold) begin
            hc++;
            @(posedge sys_clk);
        end
    endtask : wait_apply
    task automatic ev(input logic l, input logic w, input logic h);
        lv <= l;
        wdt <= w;
        halted <= h;
        @(posedge sys_clk);
        lv <= 1'b0;
        wdt <= 1'b0;
        wait_apply();
        halted <= 1'b0;
    endtask : ev
    // Kind 0 full load, 1 running timeout, 2 halt timeout
    function automatic rfi_pkg::rfi_cfg_regs_t exp_cfg(input int k);
        rfi_pkg::rfi_cfg_regs_t e;
        for (int i = 0; i < rfi_pkg::NCFG; i++) begin
            e[i] = rfi_pkg::CFG_RST[i];
            if (k == 1 && rfi_pkg::CFG_KEEP_WDT[i]) e[i] = mdl[i];
            if (k == 2 && !rfi_pkg::CFG_CLR_HALT[i]) e[i] = mdl[i];
        end
        return e;
    endfunction : exp_cfg
    task automatic chk_cfg(input int k);
        rfi_pkg::rfi_cfg_regs_t e;
        e = exp_cfg(k);
        for (int i = 0; i < rfi_pkg::NCFG; i++) begin
            rd(rfi_pkg::OFS_CFG_BASE + 8'(4 * i));
            chk(rd_v, {24'h0, e[i]});
            chk({24'h0, cfg[i]}, {24'h0, e[i]});
        end
        mdl = e;
    endtask : chk_cfg
    task automatic fill();
        logic [7:0] v;
        for (int i = 0; i < rfi_pkg::NCFG; i++) begin
            v = 8'($urandom) & rfi_pkg::CFG_MASK[i];
            if (i == 0) v = codes[nf % 4];
            wr(rfi_pkg::OFS_CFG_BASE + 8'(4 * i), {24'h0, v});
            mdl[i] = v;
        end
        nf++;
    endtask : fill
    initial begin
        void'($urandom(32'hc68b));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_apply();
        chk(32'(hc), 0);
        chk_cfg(0);
        rd(rfi_pkg::OFS_FLAGS);
        chk(rd_v, 0);
        rd(rfi_pkg::OFS_IRQ_ST);
        chk({rd_v[30:0], irq}, 32'h2);
        wr(rfi_pkg::OFS_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 1);
        wr(rfi_pkg::OFS_IRQ_ST, 32'h1f);
        chk({31'h0, irq}, 0);
        rd(8'h44);
        chk({30'h0, rs}, {30'h0, rfi_pkg::RESP_SLVERR});
        wr(8'h81, 32'h0);
        chk({30'h0, rs}, {30'h0, rfi_pkg::RESP_SLVERR});
        fill();
        wr(rfi_pkg::OFS_IRQ_MASK, 32'h4);
        ev(1'b0, 1'b1, 1'b0);
        chk({hc[29:0], to_f, pd_f}, 32'h2);
        chk({31'h0, irq}, 1);
        chk_cfg(1);
        wr(rfi_pkg::OFS_IRQ_ST, 32'h1f);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            fill();
            ev(1'b0, 1'b1, 1'b1);
            chk(32'(hc), s ? 2 : 16);
            chk({to_f, pd_f}, 2'b11);
            chk_cfg(2);
        end
        slow <= 1'b0;
        fill();
        ev(1'b1, 1'b0, 1'b0);
        chk({hc[29:0], to_f, pd_f}, 32'h3);
        chk_cfg(0);
        wr(rfi_pkg::OFS_FLAGS, 32'hf);
        wr(rfi_pkg::OFS_CFG_BASE, 32'h12);
        repeat (2) begin
            tick <= 1'b1;
            @(posedge sys_clk);
            tick <= 1'b0;
            @(posedge sys_clk);
        end
        wait_apply();
        rd(rfi_pkg::OFS_FLAGS);
        chk({31'h0, rd_v[3]}, 1);
        chk_cfg(0);
        clk_en <= 1'b0;
        lv <= 1'b1;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
        lv <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, hold}, 0);
        ev(1'b0, 1'b1, 1'b0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_apply();
        chk({to_f, pd_f, irq}, 3'b000);
        conclude();
    end
endmodule : rfi_reset_flags_tb_top
`default_nettype wire
